/* File: design/backlight_pkg.sv */
package backlight_pkg;

	localparam logic [7:0] OFF_TIMEOUT_ADDR = 8'h06;
	localparam logic [7:0] DIM_TIMEOUT_ADDR = 8'h07;
	localparam logic [7:0] FADE_RATES_ADDR = 8'h08;

	localparam logic [6:0] OFF_TIMEOUT_RESET = 7'h00;
	localparam logic [6:0] DIM_TIMEOUT_RESET = 7'h00;
	localparam logic [7:0] FADE_RATES_RESET = 8'h00;

	localparam int DELAY_MSB = 6;
	localparam int FADE_DOWN_LSB = 4;
	localparam int FADE_UP_LSB = 0;

	localparam int CLK_PERIOD_NS = 8;
	localparam int SECOND_NS = 1000000000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	// full-scale fade time unit, 0.1 s, spread over the full code range
	localparam int FADE_UNIT_MS = 100;
	localparam int FADE_STEPS = 127;
	localparam int FADE_UNIT_STEP_CYCLES = FADE_UNIT_MS * 1000000 / CLK_PERIOD_NS / FADE_STEPS;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_RISE,
		ST_FULL,
		ST_DIM_FALL,
		ST_DIM_HOLD,
		ST_OFF_FALL
	} bl_state_t;

	function automatic logic [5:0] fade_tenths(input logic [3:0] code);
		logic [5:0] t;
		t = 6'h01;
		unique case (code)
			4'h0: t = 6'h01;
			4'h1: t = 6'h03;
			4'h2: t = 6'h06;
			4'h3: t = 6'h09;
			4'h4: t = 6'h0C;
			4'h5: t = 6'h0F;
			4'h6: t = 6'h12;
			4'h7: t = 6'h15;
			4'h8: t = 6'h18;
			4'h9: t = 6'h1B;
			4'hA: t = 6'h1E;
			4'hB: t = 6'h23;
			4'hC: t = 6'h28;
			4'hD: t = 6'h2D;
			4'hE: t = 6'h32;
			4'hF: t = 6'h37;
		endcase
		return t;
	endfunction

endpackage

/* File: design/backlight_timeout_fade_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module backlight_timeout_fade_sequencer #(
	parameter int SECOND_CYCLES = backlight_pkg::SECOND_CYCLES,
	parameter int FADE_UNIT_STEP_CYCLES = backlight_pkg::FADE_UNIT_STEP_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire backlight_pkg::reg_req_t reg_req_i,
	input wire logic backlight_on_i,
	input wire logic [6:0] max_level_i,
	input wire logic [6:0] dim_level_i,
	output logic [7:0] reg_rdata_o,
	output logic [6:0] level_o,
	output logic lit_o,
	output logic dimmed_o
);

	logic [6:0] off_delay_seconds_ff;
	logic [6:0] dim_delay_seconds_ff;
	logic [3:0] fade_down_rate_ff;
	logic [3:0] fade_up_rate_ff;
	logic on_meta_ff;
	logic on_sync_ff;
	logic on_prev_ff;
	backlight_pkg::bl_state_t state_ff;
	backlight_pkg::bl_state_t nxt_state;
	logic [6:0] sec_count_ff;
	logic [6:0] target;
	logic [3:0] rate_code;
	logic [31:0] step_period;
	logic state_change;
	logic sec_tick;
	logic step_tick;
	logic switch_on;
	logic sec_counting;

	// register writes
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			off_delay_seconds_ff <= backlight_pkg::OFF_TIMEOUT_RESET;
			dim_delay_seconds_ff <= backlight_pkg::DIM_TIMEOUT_RESET;
			fade_down_rate_ff <= backlight_pkg::FADE_RATES_RESET[7:4];
			fade_up_rate_ff <= backlight_pkg::FADE_RATES_RESET[3:0];
		end else if (reg_req_i.wr) begin
			unique case (reg_req_i.addr)
				backlight_pkg::OFF_TIMEOUT_ADDR: begin
					off_delay_seconds_ff <= reg_req_i.wdata[backlight_pkg::DELAY_MSB:0];
				end
				backlight_pkg::DIM_TIMEOUT_ADDR: begin
					dim_delay_seconds_ff <= reg_req_i.wdata[backlight_pkg::DELAY_MSB:0];
				end
				backlight_pkg::FADE_RATES_ADDR: begin
					fade_down_rate_ff <= reg_req_i.wdata[backlight_pkg::FADE_DOWN_LSB +: 4];
					fade_up_rate_ff <= reg_req_i.wdata[backlight_pkg::FADE_UP_LSB +: 4];
				end
				default: begin
				end
			endcase
		end
	end

	// register reads, one cycle latency
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			unique case (reg_req_i.addr)
				backlight_pkg::OFF_TIMEOUT_ADDR: reg_rdata_o <= {1'b0, off_delay_seconds_ff};
				backlight_pkg::DIM_TIMEOUT_ADDR: reg_rdata_o <= {1'b0, dim_delay_seconds_ff};
				backlight_pkg::FADE_RATES_ADDR: reg_rdata_o <= {fade_down_rate_ff, fade_up_rate_ff};
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// enable pin synchroniser
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			on_meta_ff <= 1'b0;
			on_sync_ff <= 1'b0;
			on_prev_ff <= 1'b0;
		end else begin
			on_meta_ff <= backlight_on_i;
			on_sync_ff <= on_meta_ff;
			on_prev_ff <= on_sync_ff;
		end
	end

	assign switch_on = on_sync_ff && !on_prev_ff;

	// sequencing
	always_comb begin
		nxt_state = state_ff;
		if (switch_on) begin
			nxt_state = backlight_pkg::ST_RISE;
		end else if (!on_sync_ff && state_ff != backlight_pkg::ST_OFF) begin
			// a step landing now still fades out
			if (level_o == 7'h00 && !step_tick) begin
				nxt_state = backlight_pkg::ST_OFF;
			end else begin
				nxt_state = backlight_pkg::ST_OFF_FALL;
			end
		end else begin
			unique case (state_ff)
				backlight_pkg::ST_OFF: begin
				end
				backlight_pkg::ST_RISE: begin
					if (level_o == max_level_i) begin
						nxt_state = backlight_pkg::ST_FULL;
					end
				end
				backlight_pkg::ST_FULL: begin
					if (dim_delay_seconds_ff != 7'h00) begin
						if (sec_count_ff == dim_delay_seconds_ff) begin
							nxt_state = backlight_pkg::ST_DIM_FALL;
						end
					end else if (off_delay_seconds_ff != 7'h00
						&& sec_count_ff == off_delay_seconds_ff) begin
						nxt_state = backlight_pkg::ST_OFF_FALL;
					end
				end
				backlight_pkg::ST_DIM_FALL: begin
					if (level_o == dim_level_i) begin
						nxt_state = backlight_pkg::ST_DIM_HOLD;
					end
				end
				backlight_pkg::ST_DIM_HOLD: begin
					if (off_delay_seconds_ff != 7'h00
						&& sec_count_ff == off_delay_seconds_ff) begin
						nxt_state = backlight_pkg::ST_OFF_FALL;
					end
				end
				backlight_pkg::ST_OFF_FALL: begin
					if (level_o == 7'h00) begin
						nxt_state = backlight_pkg::ST_OFF;
					end
				end
			endcase
		end
	end

	assign state_change = (nxt_state != state_ff) || switch_on;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= backlight_pkg::ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign sec_counting = (state_ff == backlight_pkg::ST_FULL)
		|| (state_ff == backlight_pkg::ST_DIM_HOLD);

	pulse_divider sec_divider (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.clear_i(state_change || !sec_counting),
		.period_i(SECOND_CYCLES),
		.tick_o(sec_tick)
	);

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sec_count_ff <= 7'h00;
		end else if (state_change) begin
			sec_count_ff <= 7'h00;
		end else if (sec_tick && sec_count_ff != 7'h7F) begin
			sec_count_ff <= sec_count_ff + 7'h01;
		end
	end

	// ramp target and rate
	always_comb begin
		unique case (state_ff)
			backlight_pkg::ST_RISE, backlight_pkg::ST_FULL: target = max_level_i;
			backlight_pkg::ST_DIM_FALL, backlight_pkg::ST_DIM_HOLD: target = dim_level_i;
			default: target = 7'h00;
		endcase
	end

	assign rate_code = (target > level_o) ? fade_up_rate_ff : fade_down_rate_ff;

	assign step_period = 32'(backlight_pkg::fade_tenths(rate_code)) * 32'(FADE_UNIT_STEP_CYCLES);

	pulse_divider step_divider (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.clear_i(target == level_o),
		.period_i(step_period),
		.tick_o(step_tick)
	);

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			level_o <= 7'h00;
		end else if (step_tick && target > level_o) begin
			level_o <= level_o + 7'h01;
		end else if (step_tick && target < level_o) begin
			level_o <= level_o - 7'h01;
		end
	end

	// status outputs
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lit_o <= 1'b0;
			dimmed_o <= 1'b0;
		end else begin
			lit_o <= (nxt_state != backlight_pkg::ST_OFF);
			dimmed_o <= (nxt_state == backlight_pkg::ST_DIM_HOLD);
		end
	end

endmodule
`default_nettype wire

/* File: design/pulse_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_divider (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clear_i,
	input wire logic [31:0] period_i,
	output logic tick_o
);

	logic [31:0] count_ff;

	// restarts the period on clear, pulses once per period
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_ff <= 32'h00000000;
			tick_o <= 1'b0;
		end else if (clear_i) begin
			count_ff <= 32'h00000000;
			tick_o <= 1'b0;
		end else if (count_ff + 32'h00000001 >= period_i) begin
			count_ff <= 32'h00000000;
			tick_o <= 1'b1;
		end else begin
			count_ff <= count_ff + 32'h00000001;
			tick_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: tb/backlight_timeout_fade_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module backlight_timeout_fade_sequencer_bench;
	logic sys_clk_i = 1'h0;
	logic reset_n_i = 1'h0;
	backlight_pkg::reg_req_t req = '0;
	logic on = 1'h0;
	logic [7:0] rdata;
	logic [6:0] level;
	logic [6:0] sink;
	logic lit;
	logic dimmed;
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	always #4 sys_clk_i = ~sys_clk_i;
	backlight_timeout_fade_sequencer #(.SECOND_CYCLES(200), .FADE_UNIT_STEP_CYCLES(2)) u_backlight_timeout_fade_sequencer (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_req_i(req), .backlight_on_i(on),
		.max_level_i(7'h0A), .dim_level_i(7'h04), .reg_rdata_o(rdata), .level_o(level),
		.lit_o(lit), .dimmed_o(dimmed));
	led_sink_model u_led_sink_model (.sys_clk_i(sys_clk_i), .level_i(level), .lit_i(lit), .sink_code_o(sink));
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %0h seen %0h", nm, exp, got);
			err_count++;
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge sys_clk_i);
		req = '{1'h1, a, d};
		@(negedge sys_clk_i);
		req.wr = 1'h0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(negedge sys_clk_i);
		req = '{1'h0, a, 8'h00};
		@(negedge sys_clk_i);
		chk("reg_rdata_o", {24'h0, e}, {24'h0, rdata});
	endtask
	// waits for: 0 level equal, 1 level left, 2 dimmed, 3 dark
	task automatic wt(int s, logic [6:0] v);
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (n < 2000 && !(s == 0 ? level === v : s == 1 ? level !== v :
			s == 2 ? dimmed === 1'h1 : lit === 1'h0));
	endtask
	task automatic rng(string nm, int lo, int hi);
		chk(nm, 32'h1, {31'h0, n >= lo && n <= hi});
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(negedge sys_clk_i);
		reset_n_i = 1'h1;
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h00);
		wr(8'h06, 8'h81);
		rd(8'h06, 8'h01);
		wr(8'h07, 8'h81);
		rd(8'h07, 8'h01);
		wr(8'h08, 8'h10);
		rd(8'h08, 8'h10);
		wr(8'h09, 8'h5A);
		rd(8'h09, 8'h00);
		on = 1'h1;
		wt(0, 7'h0A);
		rng("rise_cycles", 21, 28);
		wt(1, 7'h0A);
		rng("dim_delay_cycles", 200, 212);
		wt(2, 7'h00);
		rng("fade_down_cycles", 28, 36);
		wt(3, 7'h00);
		rng("off_delay_cycles", 222, 232);
		on = 1'h0;
		wr(8'h07, 8'h00);
		wr(8'h06, 8'h02);
		wr(8'h08, 8'h00);
		on = 1'h1;
		wt(0, 7'h0A);
		wt(3, 7'h00);
		rng("off_only_cycles", 418, 428);
		on = 1'h0;
		repeat (4) @(negedge sys_clk_i);
		on = 1'h1;
		wt(0, 7'h0A);
		on = 1'h0;
		wt(3, 7'h00);
		rng("abort_fade_cycles", 20, 28);
		@(negedge sys_clk_i);
		chk("sink_code", 32'h0, {25'h0, sink});
		wr(8'h08, 8'h01);
		on = 1'h1;
		wt(0, 7'h0A);
		rng("slow_rise_cycles", 60, 68);
		on = 1'h0;
		wt(3, 7'h00);
		rng("second_abort_cycles", 20, 28);
		summarize();
	end
endmodule
`default_nettype wire

/* File: tb/backlight_timeout_fade_sequencer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module backlight_timeout_fade_sequencer_properties #(
	parameter int SECOND_CYCLES = 200,
	parameter int FADE_UNIT_STEP_CYCLES = 2
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire backlight_pkg::reg_req_t reg_req_i,
	input wire logic backlight_on_i,
	input wire logic [6:0] max_level_i,
	input wire logic [6:0] dim_level_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [6:0] level_o,
	input wire logic lit_o,
	input wire logic dimmed_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [7:0] a;
	assign a = reg_req_i.addr;
	a_unmapped_read_zero: assert property (!(a inside {8'h06, 8'h07, 8'h08}) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_reserved_bit_zero: assert property (a inside {8'h06, 8'h07} |=> !reg_rdata_o[7])
		else $error("reserved bit set");
	a_fade_rates_readback: assert property (reg_req_i.wr && a == 8'h08 ##1 (a == 8'h08 && !reg_req_i.wr) [*2] |=> reg_rdata_o == $past(reg_req_i.wdata, 3))
		else $error("fade rates readback");
	a_level_single_step: assert property ($changed(level_o) |-> level_o == $past(level_o) + 7'h01 || level_o == $past(level_o) - 7'h01)
		else $error("level jumped");
	a_step_spacing: assert property (FADE_UNIT_STEP_CYCLES > 1 && $changed(level_o) |=> $stable(level_o))
		else $error("steps too close");
	a_dark_when_off: assert property (!lit_o |-> level_o == 7'h00)
		else $error("level while off");
	a_dim_holds_level: assert property (dimmed_o |-> lit_o && level_o == dim_level_i)
		else $error("dim level wrong");
	a_stays_dark: assert property ((!backlight_on_i) [*4] ##0 !lit_o |=> !lit_o)
		else $error("lit without pin");
	a_level_capped: assert property (lit_o |-> level_o <= max_level_i)
		else $error("level above max");
	cover property (dimmed_o);
	cover property ($fell(lit_o));
	cover property (lit_o && level_o == max_level_i);
endmodule
bind backlight_timeout_fade_sequencer backlight_timeout_fade_sequencer_properties #(.SECOND_CYCLES(SECOND_CYCLES), .FADE_UNIT_STEP_CYCLES(FADE_UNIT_STEP_CYCLES)) u_props (
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
	.backlight_on_i(backlight_on_i), .max_level_i(max_level_i), .dim_level_i(dim_level_i),
	.reg_rdata_o(reg_rdata_o), .level_o(level_o), .lit_o(lit_o), .dimmed_o(dimmed_o));
`default_nettype wire

/* File: tb/led_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none
module led_sink_model (
	input wire logic sys_clk_i,
	input wire logic [6:0] level_i,
	input wire logic lit_i,
	output logic [6:0] sink_code_o
);
	// sinks carry current only while lit
	always_ff @(posedge sys_clk_i) begin
		sink_code_o <= lit_i ? level_i : 7'h00;
	end
endmodule
`default_nettype wire
